// >>> rtl/port_mac_learning_security.sv
// Per-port source learning, port security and aging control for a switch address table.
// Assumes the table looks up each frame's source and VLAN and reports hit, static flag and counts.
`default_nettype none
// Operation
// - Auto mode learns a new dynamic entry for an unknown source on arrival unless the table is full or a secured port is at its maximum.
// - Learning-off mode never creates entries from frames on that port.
// - Secure mode forwards only static-matching sources, drops all other frames.
// - Learning is keyed on source address together with VLAN.
// - Secured port stops learning once its learned count reaches its maximum.
// - Secured port that can no longer learn admits only sources already held in dynamic or static table.
// - Unauthorized source on secured port flags intrusion, may shut port, notifies.
// - Secured port keeps its learned addresses and exempts them from aging.
// - A port mode owned by another function ignores user configuration writes.
// - Unrefreshed dynamic entries age out; default 300 s, range 10 to 10000000 s.
// - A global switch turns aging off; then nothing ages out.
// - Table holds 8192 entries at most, of which at most 64 static.
module port_mac_learning_security
    import mac_learn_pkg::*;
#(
    parameter int ONE_SECOND_CYCLES = CYCLES_PER_SECOND
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic frame_valid,
    input wire logic [PORT_W-1:0] frame_port,
    input wire logic [ADDR_W-1:0] frame_source_address,
    input wire logic [VLAN_W-1:0] frame_vlan,
    input wire logic lookup_hit,
    input wire logic lookup_static,
    input wire logic [CNT_W-1:0] table_count,
    input wire logic [6:0] static_count,
    input wire logic remove_valid,
    input wire logic [PORT_W-1:0] remove_port,
    input wire logic [NUM_PORTS-1:0] mode_lock,
    input wire logic [2*NUM_PORTS-1:0] owner_mode,
    output logic verdict_valid,
    output logic verdict_admit,
    output logic learn_valid,
    output logic [ADDR_W-1:0] learn_address,
    output logic [VLAN_W-1:0] learn_vlan,
    output logic [PORT_W-1:0] learn_port,
    output logic static_add_valid,
    output logic [ADDR_W-1:0] static_address,
    output logic [VLAN_W-1:0] static_vlan,
    output logic [NUM_PORTS-1:0] static_members,
    output logic age_sweep,
    output logic [NUM_PORTS-1:0] age_hold_ports,
    output logic [NUM_PORTS-1:0] port_shut,
    output logic irq
);
    logic aging_off;
    logic [SEC_W-1:0] age_seconds;
    logic [2*NUM_PORTS-1:0] user_mode;
    logic [NUM_PORTS-1:0] secure_en;
    logic [NUM_PORTS-1:0] shut_en;
    logic [MAX_LEARN_W*NUM_PORTS-1:0] max_learn;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic [ADDR_W-1:0] stage_address;
    logic [VLAN_W-1:0] stage_vlan;
    logic [CNT_W-1:0] learn_count [NUM_PORTS];
    logic sweep_pulse;

    learn_mode_t eff_mode;
    logic table_full;
    logic port_secured;
    logic below_limit;
    logic next_admit;
    logic next_learn;
    logic intrusion;
    logic full_block;
    logic static_cmd;
    logic static_refused;
    logic [DATA_W-1:0] next_rdata;
    logic [SEC_W-1:0] age_written;

    assign table_full = table_count >= TABLE_CAPACITY;
    assign static_cmd = reg_wr && (reg_addr == REG_STATIC_CMD);
    assign static_refused = static_cmd && (static_count >= STATIC_CAPACITY);
    assign age_written = reg_wdata[SEC_W-1:0];

    // Frame decision; the source/VLAN pair is what the table looked up
    always_comb begin
        eff_mode = learn_mode_t'(mode_lock[frame_port] ? owner_mode[2*frame_port +: 2]
                                                       : user_mode[2*frame_port +: 2]);
        port_secured = secure_en[frame_port];
        below_limit = learn_count[frame_port] < CNT_W'(max_learn[MAX_LEARN_W*frame_port +: MAX_LEARN_W]);
        next_admit = 1'b0;
        next_learn = 1'b0;
        intrusion = 1'b0;
        full_block = 1'b0;
        if (frame_valid && !port_shut[frame_port]) begin
            case (eff_mode)
                MODE_AUTO: begin
                    if (lookup_hit) begin
                        next_admit = 1'b1;
                    end else if (!port_secured) begin
                        next_admit = 1'b1;
                        next_learn = !table_full;
                        full_block = table_full;
                    end else if (below_limit && !table_full) begin
                        next_admit = 1'b1;
                        next_learn = 1'b1;
                    end else begin
                        intrusion = 1'b1;
                        full_block = table_full;
                    end
                end
                MODE_OFF: begin
                    next_admit = lookup_hit || !port_secured;
                    intrusion = port_secured && !lookup_hit;
                end
                MODE_SECURE: begin
                    next_admit = lookup_hit && lookup_static;
                    intrusion = port_secured && !next_admit;
                end
                default: begin
                    next_admit = 1'b0;
                end
            endcase
        end
    end

    // Frame verdict and learn request, one cycle after the lookup result
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            verdict_valid <= 1'b0;
            verdict_admit <= 1'b0;
            learn_valid <= 1'b0;
            learn_address <= '0;
            learn_vlan <= '0;
            learn_port <= '0;
        end else begin
            verdict_valid <= frame_valid;
            verdict_admit <= next_admit;
            learn_valid <= next_learn;
            if (next_learn) begin
                learn_address <= frame_source_address;
                learn_vlan <= frame_vlan;
                learn_port <= frame_port;
            end
        end
    end

    // Learned address counters; a learn and a removal on one port cancel out
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                learn_count[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (next_learn && frame_port == PORT_W'(p)
                        && !(remove_valid && remove_port == PORT_W'(p))) begin
                    learn_count[p] <= learn_count[p] + 1'b1;
                end else if (remove_valid && remove_port == PORT_W'(p)
                        && !(next_learn && frame_port == PORT_W'(p)) && learn_count[p] != '0) begin
                    learn_count[p] <= learn_count[p] - 1'b1;
                end
            end
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            aging_off <= 1'b0;
            age_seconds <= AGE_DEFAULT_S;
            user_mode <= '0;
            secure_en <= '0;
            shut_en <= '0;
            max_learn <= {NUM_PORTS{MAX_LEARN_DEFAULT}};
            int_mask <= '0;
            stage_address <= '0;
            stage_vlan <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_GLOBAL: aging_off <= reg_wdata[GLOBAL_AGING_OFF_BIT];
                REG_AGE_TIME: begin
                    // Out-of-range values are clamped rather than rejected
                    if (age_written < AGE_MIN_S) begin
                        age_seconds <= AGE_MIN_S;
                    end else if (age_written > AGE_MAX_S) begin
                        age_seconds <= AGE_MAX_S;
                    end else begin
                        age_seconds <= age_written;
                    end
                end
                REG_PORT_MODE: begin
                    for (int p = 0; p < NUM_PORTS; p++) begin
                        if (!mode_lock[p]) begin
                            user_mode[2*p +: 2] <= reg_wdata[2*p +: 2];
                        end
                    end
                end
                REG_SECURITY: begin
                    secure_en <= reg_wdata[NUM_PORTS-1:0];
                    shut_en <= reg_wdata[SECURITY_SHUT_LSB +: NUM_PORTS];
                end
                REG_MAX_LEARN: max_learn <= reg_wdata[MAX_LEARN_W*NUM_PORTS-1:0];
                REG_INT_MASK: int_mask <= reg_wdata[INT_W-1:0];
                REG_STATIC_LO: stage_address[31:0] <= reg_wdata;
                REG_STATIC_HI: begin
                    stage_address[ADDR_W-1:32] <= reg_wdata[ADDR_W-33:0];
                    stage_vlan <= reg_wdata[STATIC_VLAN_LSB +: VLAN_W];
                end
                default: begin
                    aging_off <= aging_off;
                end
            endcase
        end
    end

    // Static entry insertion, refused once the static part of the table is full
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            static_add_valid <= 1'b0;
            static_address <= '0;
            static_vlan <= '0;
            static_members <= '0;
        end else begin
            static_add_valid <= static_cmd && !static_refused;
            if (static_cmd && !static_refused) begin
                static_address <= stage_address;
                static_vlan <= stage_vlan;
                static_members <= reg_wdata[NUM_PORTS-1:0];
            end
        end
    end

    // Port shutdown on intrusion; software re-enables by writing one, a new intrusion wins
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            port_shut <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (intrusion && frame_port == PORT_W'(p) && shut_en[p]) begin
                    port_shut[p] <= 1'b1;
                end else if (reg_wr && reg_addr == REG_PORT_SHUT && reg_wdata[p]) begin
                    port_shut[p] <= 1'b0;
                end
            end
        end
    end

    // Sticky event bits, write one to clear; a same-cycle event keeps its bit set
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            int_status <= '0;
        end else begin
            for (int b = 0; b < INT_W; b++) begin
                if ((b < NUM_PORTS && intrusion && frame_port == PORT_W'(b))
                        || (b == INT_FULL_BIT && full_block)
                        || (b == INT_STATIC_BIT && static_refused)) begin
                    int_status[b] <= 1'b1;
                end else if (reg_wr && reg_addr == REG_INT_STATUS && reg_wdata[b]) begin
                    int_status[b] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end

    age_timer #(
        .ONE_SECOND_CYCLES(ONE_SECOND_CYCLES)
    ) u_age_timer (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .enable(!aging_off),
        .age_seconds(age_seconds),
        .sweep(sweep_pulse)
    );

    // Table ages unrefreshed dynamic entries on each sweep, sparing ports held here
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            age_sweep <= 1'b0;
            age_hold_ports <= '0;
        end else begin
            age_sweep <= sweep_pulse && !aging_off;
            age_hold_ports <= secure_en;
        end
    end

    // Register read mux
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            REG_GLOBAL: next_rdata[GLOBAL_AGING_OFF_BIT] = aging_off;
            REG_AGE_TIME: next_rdata[SEC_W-1:0] = age_seconds;
            REG_PORT_MODE: begin
                for (int p = 0; p < NUM_PORTS; p++) begin
                    next_rdata[2*p +: 2] = mode_lock[p] ? owner_mode[2*p +: 2] : user_mode[2*p +: 2];
                end
            end
            REG_SECURITY: begin
                next_rdata[NUM_PORTS-1:0] = secure_en;
                next_rdata[SECURITY_SHUT_LSB +: NUM_PORTS] = shut_en;
            end
            REG_MAX_LEARN: next_rdata[MAX_LEARN_W*NUM_PORTS-1:0] = max_learn;
            REG_PORT_SHUT: next_rdata[NUM_PORTS-1:0] = port_shut;
            REG_INT_STATUS: next_rdata[INT_W-1:0] = int_status;
            REG_INT_MASK: next_rdata[INT_W-1:0] = int_mask;
            REG_MODE_LOCK: next_rdata[NUM_PORTS-1:0] = mode_lock;
            REG_STATIC_LO: next_rdata = stage_address[31:0];
            REG_STATIC_HI: begin
                next_rdata[ADDR_W-33:0] = stage_address[ADDR_W-1:32];
                next_rdata[STATIC_VLAN_LSB +: VLAN_W] = stage_vlan;
            end
            default: begin
                for (int p = 0; p < NUM_PORTS; p++) begin
                    if (reg_addr == REG_COUNT_BASE + REG_AW'(4 * p)) begin
                        next_rdata[CNT_W-1:0] = learn_count[p];
                    end
                end
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule : port_mac_learning_security
`default_nettype wire

// >>> rtl/mac_learn_pkg.sv
// Constants, register map and mode encodings for the port learning and security block.
// Assumes a single 10 MHz clock and a 32-bit byte-addressed register port.
`default_nettype none
package mac_learn_pkg;
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 2;
    localparam int ADDR_W = 48;
    localparam int VLAN_W = 12;
    localparam int CNT_W = 14;
    localparam int SEC_W = 24;
    localparam int REG_AW = 8;
    localparam int DATA_W = 32;

    localparam logic [CNT_W-1:0] TABLE_CAPACITY = 14'h2000;
    localparam logic [6:0] STATIC_CAPACITY = 7'h40;

    localparam logic [SEC_W-1:0] AGE_DEFAULT_S = 24'h00012c;
    localparam logic [SEC_W-1:0] AGE_MIN_S = 24'h00000a;
    localparam logic [SEC_W-1:0] AGE_MAX_S = 24'h989680;

    localparam int SECOND_NS = 1000000000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;

    localparam logic [REG_AW-1:0] REG_GLOBAL = 8'h00;
    localparam logic [REG_AW-1:0] REG_AGE_TIME = 8'h04;
    localparam logic [REG_AW-1:0] REG_PORT_MODE = 8'h08;
    localparam logic [REG_AW-1:0] REG_SECURITY = 8'h0c;
    localparam logic [REG_AW-1:0] REG_MAX_LEARN = 8'h10;
    localparam logic [REG_AW-1:0] REG_PORT_SHUT = 8'h14;
    localparam logic [REG_AW-1:0] REG_INT_STATUS = 8'h18;
    localparam logic [REG_AW-1:0] REG_INT_MASK = 8'h1c;
    localparam logic [REG_AW-1:0] REG_MODE_LOCK = 8'h20;
    localparam logic [REG_AW-1:0] REG_STATIC_LO = 8'h24;
    localparam logic [REG_AW-1:0] REG_STATIC_HI = 8'h28;
    localparam logic [REG_AW-1:0] REG_STATIC_CMD = 8'h2c;
    localparam logic [REG_AW-1:0] REG_COUNT_BASE = 8'h40;

    localparam int GLOBAL_AGING_OFF_BIT = 0;
    localparam int SECURITY_SHUT_LSB = 4;
    localparam int MAX_LEARN_W = 8;
    localparam int INT_FULL_BIT = 4;
    localparam int INT_STATIC_BIT = 5;
    localparam int INT_W = 6;
    localparam int STATIC_VLAN_LSB = 16;

    localparam logic [MAX_LEARN_W-1:0] MAX_LEARN_DEFAULT = 8'h04;

    typedef enum logic [1:0] {
        MODE_AUTO = 2'b00,
        MODE_OFF = 2'b01,
        MODE_SECURE = 2'b11
    } learn_mode_t;
endpackage : mac_learn_pkg
`default_nettype wire

// >>> rtl/age_timer.sv
// Aging period timer: one-second enable from a divider, then a count of seconds.
// Assumes age_seconds is already clamped to the legal range by the register logic.
`default_nettype none
module age_timer
    import mac_learn_pkg::*;
#(
    parameter int ONE_SECOND_CYCLES = CYCLES_PER_SECOND
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [SEC_W-1:0] age_seconds,
    output logic sweep
);
    logic [SEC_W-1:0] cycle_count;
    logic [SEC_W-1:0] second_count;
    logic second_tick;

    always_ff @(posedge ref_clk) begin
        if (!rst_b || !enable) begin
            cycle_count <= '0;
            second_tick <= 1'b0;
        end else if (cycle_count == SEC_W'(ONE_SECOND_CYCLES - 1)) begin
            cycle_count <= '0;
            second_tick <= 1'b1;
        end else begin
            cycle_count <= cycle_count + 1'b1;
            second_tick <= 1'b0;
        end
    end

    // Disabling aging restarts the period so that no sweep fires while it is off
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !enable) begin
            second_count <= '0;
            sweep <= 1'b0;
        end else if (second_tick && (second_count >= age_seconds - 1'b1)) begin
            second_count <= '0;
            sweep <= 1'b1;
        end else begin
            if (second_tick) begin
                second_count <= second_count + 1'b1;
            end
            sweep <= 1'b0;
        end
    end
endmodule : age_timer
`default_nettype wire

// >>> tb/mac_learn_checker.sv
// Port-level assertions for the learning and security block.
// Assumes the single ref_clk domain with synchronous active-low rst_b.
`default_nettype none
module mac_learn_checker
    import mac_learn_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic frame_valid,
    input wire logic [PORT_W-1:0] frame_port,
    input wire logic [ADDR_W-1:0] frame_source_address,
    input wire logic [VLAN_W-1:0] frame_vlan,
    input wire logic lookup_hit,
    input wire logic [CNT_W-1:0] table_count,
    input wire logic [6:0] static_count,
    input wire logic verdict_valid,
    input wire logic verdict_admit,
    input wire logic learn_valid,
    input wire logic [ADDR_W-1:0] learn_address,
    input wire logic [VLAN_W-1:0] learn_vlan,
    input wire logic [PORT_W-1:0] learn_port,
    input wire logic static_add_valid,
    input wire logic age_sweep,
    input wire logic [NUM_PORTS-1:0] port_shut
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_verdict_follows: assert property (frame_valid |=> verdict_valid)
        else $error("verdict missing after frame");
    a_no_stray_verdict: assert property (!frame_valid |=> !verdict_valid)
        else $error("verdict without frame");
    a_learn_on_frame: assert property (learn_valid |-> $past(frame_valid) && !$past(lookup_hit))
        else $error("learn without missed frame");
    a_learn_key: assert property (learn_valid |-> learn_address == $past(frame_source_address)
        && learn_vlan == $past(frame_vlan) && learn_port == $past(frame_port))
        else $error("learned key differs from frame");
    a_full_no_learn: assert property (frame_valid && table_count >= TABLE_CAPACITY |=> !learn_valid)
        else $error("learn into full table");
    a_learn_admits: assert property (learn_valid |-> verdict_valid && verdict_admit)
        else $error("learned frame not admitted");
    a_shut_drops: assert property (frame_valid && port_shut[frame_port] |=>
        verdict_valid && !verdict_admit && !learn_valid)
        else $error("frame on shut port passed");
    a_shut_cause: assert property ((port_shut & ~$past(port_shut)) != '0 |->
        verdict_valid && !verdict_admit)
        else $error("port shut without dropped frame");
    a_static_limit: assert property (static_add_valid |-> $past(static_count) < STATIC_CAPACITY)
        else $error("static add beyond capacity");
    a_sweep_gap: assert property (age_sweep |=> !age_sweep [*8])
        else $error("sweeps too close");

    c_learn: cover property (learn_valid);
    c_full: cover property (frame_valid && table_count >= TABLE_CAPACITY);
    c_shut: cover property ($rose(port_shut[3]));
    c_static: cover property (static_add_valid);
endmodule : mac_learn_checker

bind port_mac_learning_security mac_learn_checker mac_learn_checker_inst (.*);
`default_nettype wire

// >>> tb/mac_table_model.sv
// Address table stand-in: keeps total and static entry counts for the block.
// Assumes learn and static-add pulses from the block; the bench may preload counts.
`default_nettype none
module mac_table_model
    import mac_learn_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic learn_valid,
    input wire logic static_add_valid,
    input wire logic preset_valid,
    input wire logic [CNT_W-1:0] preset_count,
    input wire logic [6:0] preset_static,
    output logic [CNT_W-1:0] table_count,
    output logic [6:0] static_count
);
    // Counts saturate at capacity, as the real table refuses further inserts
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            table_count <= '0;
            static_count <= '0;
        end else if (preset_valid) begin
            table_count <= preset_count;
            static_count <= preset_static;
        end else begin
            if (learn_valid && table_count < TABLE_CAPACITY)
                table_count <= table_count + 1'b1;
            if (static_add_valid && static_count < STATIC_CAPACITY)
                static_count <= static_count + 1'b1;
        end
    end
endmodule : mac_table_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench: register port, frame decisions, security, aging.
// Assumes the table model beside the block and a sped-up one-second divider.
`default_nettype none
module tb_top;
    import mac_learn_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, frame_valid = 1'b0, lookup_hit = 1'b0, lookup_static = 1'b0;
    logic remove_valid = 1'b0, preset_valid = 1'b0;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic [PORT_W-1:0] frame_port = '0, remove_port = '0, learn_port;
    logic [ADDR_W-1:0] frame_source_address = '0, learn_address, static_address;
    logic [VLAN_W-1:0] frame_vlan = '0, learn_vlan, static_vlan;
    logic [CNT_W-1:0] table_count, preset_count = '0;
    logic [6:0] static_count, preset_static = '0;
    logic [NUM_PORTS-1:0] mode_lock = '0, static_members, age_hold_ports, port_shut;
    logic [2*NUM_PORTS-1:0] owner_mode = '0;
    logic verdict_valid, verdict_admit, learn_valid, static_add_valid, age_sweep, irq;
    int fail_count = 0, n_checks = 0, cycles = 0;

    always #50 ref_clk = ~ref_clk;

    port_mac_learning_security #(.ONE_SECOND_CYCLES(10)) port_mac_learning_security_inst (.*);
    mac_table_model mac_table_model_inst (.*);

    task automatic test_done;
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask : chk

    task automatic reg_write(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [REG_AW-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // One frame with a fresh random key; verdict and learn are seen one cycle later
    task automatic frame(input logic [1:0] p, input logic h, input logic s, input logic ea, input logic el);
        @(posedge ref_clk);
        frame_valid <= 1'b1;
        frame_port <= p;
        frame_source_address <= {16'($urandom), $urandom};
        frame_vlan <= 12'($urandom);
        lookup_hit <= h;
        lookup_static <= s;
        @(posedge ref_clk);
        frame_valid <= 1'b0;
        #1;
        chk("verdict", {1'b1, ea, el}, {verdict_valid, verdict_admit, learn_valid});
    endtask : frame

    task automatic preset(input logic [CNT_W-1:0] c, input logic [6:0] s);
        @(posedge ref_clk);
        preset_valid <= 1'b1;
        preset_count <= c;
        preset_static <= s;
        @(posedge ref_clk);
        preset_valid <= 1'b0;
    endtask : preset

    task automatic next_sweep(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (!age_sweep && n < 400);
    endtask : next_sweep

    function automatic logic fn_admit(input logic [1:0] m, input logic h, input logic s);
        return (m == MODE_SECURE) ? (h && s) : (m != 2'b10);
    endfunction : fn_admit

    initial begin
        logic [DATA_W-1:0] d;
        logic [1:0] m;
        logic h, s;
        int n;
        void'($urandom(11));
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        reg_read(REG_AGE_TIME, d);
        chk("age_default", 64'(AGE_DEFAULT_S), 64'(d));
        reg_read(8'h3c, d);
        chk("unmapped", 64'h0, 64'(d));
        for (int i = 0; i < 40; i++) begin
            m = 2'($urandom);
            h = 1'($urandom);
            s = 1'($urandom);
            reg_write(REG_PORT_MODE, {30'h0, m});
            frame(2'd0, h, s, fn_admit(m, h, s), m == MODE_AUTO && !h);
        end
        reg_write(REG_PORT_MODE, 32'h01);
        frame(2'd0, 1'b0, 1'b0, 1'b1, 1'b0);
        reg_write(REG_PORT_MODE, 32'h03);
        frame(2'd0, 1'b1, 1'b0, 1'b0, 1'b0);
        frame(2'd0, 1'b1, 1'b1, 1'b1, 1'b0);
        // Owner forces secure on port 1; the user write of learning-off must not stick
        mode_lock <= 4'b0010;
        owner_mode <= 8'h0c;
        reg_write(REG_PORT_MODE, 32'h04);
        reg_read(REG_PORT_MODE, d);
        chk("locked_mode", 64'h0c, 64'(d));
        frame(2'd1, 1'b0, 1'b0, 1'b0, 1'b0);
        mode_lock <= 4'b0000;
        reg_write(REG_MAX_LEARN, 32'h02040404);
        reg_write(REG_SECURITY, 32'h88);
        reg_write(REG_INT_MASK, 32'h08);
        chk("age_hold", 64'h8, 64'(age_hold_ports));
        frame(2'd3, 1'b0, 1'b0, 1'b1, 1'b1);
        frame(2'd3, 1'b0, 1'b0, 1'b1, 1'b1);
        frame(2'd3, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("shut", 64'h8, 64'(port_shut));
        reg_read(REG_COUNT_BASE + 8'h0c, d);
        chk("learn_count", 64'h2, 64'(d));
        @(posedge ref_clk);
        remove_port <= 2'd3;
        remove_valid <= 1'b1;
        @(posedge ref_clk);
        remove_valid <= 1'b0;
        reg_read(REG_COUNT_BASE + 8'h0c, d);
        chk("unlearn_count", 64'h1, 64'(d));
        chk("irq_set", 64'h1, 64'(irq));
        frame(2'd3, 1'b1, 1'b0, 1'b0, 1'b0);
        reg_write(REG_PORT_SHUT, 32'h08);
        reg_write(REG_INT_STATUS, 32'h08);
        frame(2'd3, 1'b1, 1'b0, 1'b1, 1'b0);
        chk("irq_clear", 64'h0, 64'({irq, port_shut}));
        reg_write(REG_SECURITY, 32'h0);
        preset(TABLE_CAPACITY, 7'd63);
        frame(2'd0, 1'b0, 1'b0, 1'b1, 1'b0);
        reg_read(REG_INT_STATUS, d);
        chk("full_status", 64'h10, 64'(d));
        reg_write(REG_INT_STATUS, 32'h10);
        preset(14'd10, 7'd63);
        reg_write(REG_STATIC_LO, 32'hdeadbeef);
        reg_write(REG_STATIC_HI, 32'h01230a0b);
        for (int j = 0; j < 2; j++) begin
            reg_write(REG_STATIC_CMD, 32'h5);
            #1;
            chk("static_add", 64'(j == 0), 64'(static_add_valid));
        end
        chk("static_key", {12'h123, 48'h0a0bdeadbeef, 4'h5},
            {static_vlan, static_address, static_members});
        reg_read(REG_INT_STATUS, d);
        chk("static_full", 64'h20, 64'(d));
        reg_write(REG_AGE_TIME, 32'h5);
        reg_read(REG_AGE_TIME, d);
        chk("age_clamp", 64'(AGE_MIN_S), 64'(d));
        next_sweep(n);
        next_sweep(n);
        chk("sweep_period", 64'h1, 64'(n >= 99 && n <= 102));
        reg_write(REG_GLOBAL, 32'h1);
        n = 0;
        repeat (250) begin
            @(posedge ref_clk);
            #1;
            n += age_sweep;
        end
        chk("sweep_off", 64'h0, 64'(n));
        test_done();
    end
endmodule : tb_top
`default_nettype wire
